// ### incr_lit_core.sv
// Executes increment and literal-load instructions on a small register file.
// Assumes a classic Wishbone master writes instruction words and reads state.
//
// Notes on behaviour
// - Upper byte 0001 010d increments file register at low-byte address.
// - Destination bit 0 writes working register, 1 writes the file register.
// - 1011 101x copies literal nibble into bank select bits 7:4, one cycle.
// - Bank select lower nibble stays unchanged on that load.
// - 1011 0000 kkkkkkkk loads literal into working register, flags untouched.
`timescale 1ns/1ns
module incr_lit_core
  import incr_lit_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic      [7:0]  working_register_o,
  output logic      [7:0]  bank_select_register_o,
  output logic             skip_o
);

  // ****************************************************************
  // Increment arithmetic
  // ****************************************************************
  function automatic inc_res_t inc8(input logic [7:0] v);
    inc_res_t r;
    logic [8:0] s;
    s = {1'b0, v} + 9'h001;
    r.result = s[7:0];
    r.flags.carry = s[8];
    r.flags.low_nibble_wrap_flag = (v[3:0] == 4'hf);
    r.flags.zero = (s[7:0] == 8'h00);
    r.flags.signed_wrap_flag = (v == 8'h7f);
    return r;
  endfunction : inc8

  // ****************************************************************
  // Opcode decoding
  // ****************************************************************
  function automatic logic is_inc(input logic [15:0] w);
    return w[15:9] == OP_INC_HI7;
  endfunction : is_inc

  function automatic logic is_incsz(input logic [15:0] w);
    return w[15:9] == OP_INCSZ_HI7;
  endfunction : is_incsz

  function automatic logic is_ldbank(input logic [15:0] w);
    return w[15:9] == OP_LDBANK_HI7;
  endfunction : is_ldbank

  function automatic logic is_ldw(input logic [15:0] w);
    return w[15:8] == OP_LDW_HI8;
  endfunction : is_ldw

  logic [7:0] file_q [FILE_DEPTH];
  logic [7:0] work_q, work_d;
  logic [7:0] bank_q, bank_d;
  flags_t     flags_q, flags_d;
  logic       skip_q, skip_d;
  logic       ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] faddr_q, faddr_d;
  logic       fwe;
  logic [7:0] fwa, fwd;
  logic [15:0] instr;
  logic        exec;
  logic        req;
  inc_res_t    ir;

  assign req   = cyc_i && stb_i && !ack_q;
  assign exec  = req && we_i && (adr_i == REG_INSTR) && (sel_i[1:0] == 2'b11);
  assign instr = dat_i[15:0];
  assign ir    = inc8(file_q[instr[7:0]]);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    work_d  = work_q;
    bank_d  = bank_q;
    flags_d = flags_q;
    skip_d  = skip_q;
    faddr_d = faddr_q;
    fwe     = 1'b0;
    fwa     = instr[7:0];
    fwd     = ir.result;
    ack_d   = req;
    rdat_d  = 32'h0000_0000;
    if (exec) begin
      if (skip_q) begin
        skip_d = 1'b0;
      end else if (is_inc(instr)) begin
        if (instr[8]) begin
          fwe = 1'b1;
        end else begin
          work_d = ir.result;
        end
        flags_d = ir.flags;
      end else if (is_incsz(instr)) begin
        if (instr[8]) begin
          fwe = 1'b1;
        end else begin
          work_d = ir.result;
        end
        skip_d = ir.flags.zero;
      end else if (is_ldbank(instr)) begin
        bank_d = {instr[7:4], bank_q[3:0]};
      end else if (is_ldw(instr)) begin
        work_d = instr[7:0];
      end
    end else if (req && we_i) begin
      case (adr_i)
        REG_WORK: begin
          if (sel_i[0]) work_d = dat_i[7:0];
        end
        REG_BANK: begin
          if (sel_i[0]) bank_d = dat_i[7:0];
        end
        REG_FLAGS: begin
          if (sel_i[0]) flags_d = flags_t'(dat_i[3:0]);
        end
        REG_FADDR: begin
          if (sel_i[0]) faddr_d = dat_i[7:0];
        end
        REG_FDATA: begin
          fwe = sel_i[0];
          fwa = faddr_q;
          fwd = dat_i[7:0];
        end
        default: begin
        end
      endcase
    end else if (req) begin
      case (adr_i)
        REG_CTRL:  rdat_d = {31'h0, skip_q};
        REG_WORK:  rdat_d = {24'h0, work_q};
        REG_BANK:  rdat_d = {24'h0, bank_q};
        REG_FLAGS: rdat_d = {28'h0, flags_q};
        REG_FADDR: rdat_d = {24'h0, faddr_q};
        REG_FDATA: rdat_d = {24'h0, file_q[faddr_q]};
        default:   rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_q  <= WORK_RST;
      bank_q  <= BANK_RST;
      flags_q <= flags_t'(FLAGS_RST);
      skip_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
      faddr_q <= 8'h00;
    end else begin
      work_q  <= work_d;
      bank_q  <= bank_d;
      flags_q <= flags_d;
      skip_q  <= skip_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      faddr_q <= faddr_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (fwe) begin
      file_q[fwa] <= fwd;
    end
  end

  assign dat_o                  = rdat_q;
  assign ack_o                  = ack_q;
  assign working_register_o     = work_q;
  assign bank_select_register_o = bank_q;
  assign skip_o                 = skip_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bank_low_keep: assert property (
    exec && !skip_q && instr[15:9] == OP_LDBANK_HI7
    |=> bank_q[3:0] == $past(bank_q[3:0]) && bank_q[7:4] == $past(instr[7:4]))
    else $error("bank load wrong");

  chk_litw_load: assert property (
    exec && !skip_q && instr[15:8] == OP_LDW_HI8
    |=> work_q == $past(instr[7:0]) && flags_q == $past(flags_q))
    else $error("literal load wrong");

  chk_inc_work: assert property (
    exec && !skip_q && instr[15:9] == OP_INC_HI7 && !instr[8]
    |=> work_q == $past(ir.result))
    else $error("increment to working wrong");

  chk_inc_flags: assert property (
    exec && !skip_q && instr[15:9] == OP_INC_HI7
    |=> flags_q == $past(ir.flags))
    else $error("increment flags wrong");

  chk_skip_set: assert property (
    exec && !skip_q && instr[15:9] == OP_INCSZ_HI7
    |=> skip_q == $past(ir.flags.zero) && flags_q == $past(flags_q))
    else $error("skip decision wrong");

  chk_skip_drop: assert property (
    exec && skip_q |=> !skip_q && work_q == $past(work_q) && bank_q == $past(bank_q))
    else $error("discarded word executed");

  chk_inc_file: assert property (
    exec && !skip_q && instr[15:9] == OP_INC_HI7 && instr[8]
    |=> file_q[$past(instr[7:0])] == $past(ir.result))
    else $error("file increment wrong");

  chk_incsz_work: assert property (
    exec && !skip_q && is_incsz(instr) && !instr[8]
    |=> work_q == 8'($past(file_q[instr[7:0]]) + 8'h01))
    else $error("skip increment to working wrong");

  chk_incsz_file: assert property (
    exec && !skip_q && is_incsz(instr) && instr[8]
    |=> file_q[$past(instr[7:0])] == $past(ir.result))
    else $error("skip increment to file wrong");

  chk_skip_hold: assert property (
    skip_q && !exec |=> skip_q)
    else $error("pending skip lost");

  chk_inc_carry: assert property (
    exec && !skip_q && is_inc(instr)
    |=> flags_q.carry == ($past(file_q[instr[7:0]]) == 8'hff))
    else $error("increment carry wrong");

  chk_inc_zero: assert property (
    exec && !skip_q && is_inc(instr)
    |=> flags_q.zero == ($past(file_q[instr[7:0]]) == 8'hff))
    else $error("increment zero wrong");

  chk_bank_work: assert property (
    exec && !skip_q && is_ldbank(instr)
    |=> work_q == $past(work_q) && flags_q == $past(flags_q))
    else $error("bank load touched other state");

  chk_litw_bank: assert property (
    exec && !skip_q && is_ldw(instr) |=> bank_q == $past(bank_q))
    else $error("literal load touched bank");

  // ****************************************************************
  // Bus handshake, read data and register write checks
  // ****************************************************************

  chk_ack_pulse: assert property (ack_q |=> !ack_q)
    else $error("ack held too long");

  chk_ack_answer: assert property (req |=> ack_q)
    else $error("request not answered");

  chk_read_idle: assert property (!ack_q |-> rdat_q == 32'h0000_0000)
    else $error("read data outside answer");

  chk_bank_write: assert property (
    req && we_i && adr_i == REG_BANK && sel_i[0] |=> bank_q == $past(dat_i[7:0]))
    else $error("bank register write lost");

  chk_work_write: assert property (
    req && we_i && adr_i == REG_WORK && sel_i[0] |=> work_q == $past(dat_i[7:0]))
    else $error("working register write lost");

  chk_fdata_write: assert property (
    req && we_i && adr_i == REG_FDATA && sel_i[0]
    |=> file_q[$past(faddr_q)] == $past(dat_i[7:0]))
    else $error("file data write lost");

  // ****************************************************************
  // Coverage
  // ****************************************************************

  cov_skip: cover property (exec && skip_q);
  cov_wrap: cover property (exec && instr[15:9] == OP_INC_HI7 && ir.flags.carry);
  cov_bank: cover property (exec && instr[15:9] == OP_LDBANK_HI7);
  cov_noskip: cover property (exec && !skip_q && is_incsz(instr) && !ir.flags.zero);
  cov_litw: cover property (exec && !skip_q && is_ldw(instr));

endmodule : incr_lit_core

// ### incr_lit_pkg.sv
// Package for the increment and literal-load instruction block.
// Assumes a single 125 MHz core clock and classic Wishbone register access.
package incr_lit_pkg;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [6:0] OP_INC_HI7   = 7'h0a;  // 0001 010d
  localparam logic [6:0] OP_INCSZ_HI7 = 7'h0f;  // 0001 111d
  localparam logic [6:0] OP_LDBANK_HI7 = 7'h5d; // 1011 101x
  localparam logic [7:0] OP_LDW_HI8   = 8'hb0;  // 1011 0000

  // ****************************************************************
  // Register map (word offsets as byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_INSTR  = 8'h04;
  localparam logic [7:0] REG_WORK   = 8'h08;
  localparam logic [7:0] REG_BANK   = 8'h0c;
  localparam logic [7:0] REG_FLAGS  = 8'h10;
  localparam logic [7:0] REG_FADDR  = 8'h14;
  localparam logic [7:0] REG_FDATA  = 8'h18;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int FLAG_C   = 0;
  localparam int FLAG_NIB = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_SWRAP = 3;
  localparam int CTRL_SKIP = 0;
  localparam logic [7:0] WORK_RST  = 8'h00;
  localparam logic [7:0] BANK_RST  = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam int FILE_DEPTH = 256;

  typedef struct packed {
    logic       signed_wrap_flag;
    logic       zero;
    logic       low_nibble_wrap_flag;
    logic       carry;
  } flags_t;

  typedef struct packed {
    logic [7:0] result;
    flags_t     flags;
  } inc_res_t;

endpackage : incr_lit_pkg

// ### prog_mem_model.sv
// Program memory model: hands out 16-bit instruction words by index.
// Assumes the bench copies each fetched word into the instruction register.
`timescale 1ns/1ns
module prog_mem_model (
  input  wire logic [2:0]  pc_i,
  output logic      [15:0] word_o
);
  // ****************************************************************
  // Program image
  // ****************************************************************
  always_comb begin
    case (pc_i)
      3'd0:    word_o = 16'hb0ff;
      3'd1:    word_o = 16'hbb53;
      3'd2:    word_o = 16'h1580;
      3'd3:    word_o = 16'h1480;
      3'd4:    word_o = 16'h1f80;
      3'd5:    word_o = 16'hb0aa;
      3'd6:    word_o = 16'hb0aa;
      default: word_o = 16'h1e80;
    endcase
  end
endmodule : prog_mem_model

// ### tb_increment_and_literal_ops.sv
// Testbench for the increment and literal-load block.
// Assumes a Wishbone slave that answers one cycle after the taking edge.
`timescale 1ns/1ns
module tb_increment_and_literal_ops;
  import incr_lit_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic        ack_o;
  logic        skip_o;
  logic [7:0]  working_register_o;
  logic [7:0]  bank_select_register_o;
  logic [2:0]  pc = 3'h0;
  logic [15:0] word;
  int          errors = 0;
  int          check_count = 0;
  always #4 clk_i = ~clk_i;
  incr_lit_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .working_register_o(working_register_o),
    .bank_select_register_o(bank_select_register_o), .skip_o(skip_o));
  prog_mem_model mem_u (.pc_i(pc), .word_o(word));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic run(input logic [2:0] i);
    pc <= i;
    @(posedge clk_i);
    wb(1'b1, REG_INSTR, {16'h0, word});
  endtask : run
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(REG_WORK, 32'h0, "work");
    rd(REG_BANK, 32'h0, "bank");
    rd(8'hfc, 32'h0, "unmapped");
    chk("skip", skip_o, 1'b0);
  endtask : t_reset
  task automatic t_literal;
    wb(1'b1, REG_FLAGS, 32'hf);
    run(3'd0);
    chk("work", working_register_o, 8'hff);
    rd(REG_FLAGS, 32'hf, "flags");
    wb(1'b1, REG_BANK, 32'h22);
    run(3'd1);
    chk("bank", bank_select_register_o, 8'h52);
    chk("work", working_register_o, 8'hff);
  endtask : t_literal
  task automatic t_inc;
    wb(1'b1, REG_FADDR, 32'h80);
    wb(1'b1, REG_FDATA, 32'hff);
    run(3'd2);
    rd(REG_FDATA, 32'h0, "file");
    chk("work", working_register_o, 8'hff);
    rd(REG_FLAGS, 32'((1 << FLAG_C) | (1 << FLAG_NIB) | (1 << FLAG_Z)), "flags");
    run(3'd3);
    chk("work", working_register_o, 8'h01);
    rd(REG_FDATA, 32'h0, "file");
    rd(REG_FLAGS, 32'h0, "flags");
  endtask : t_inc
  task automatic t_skip;
    wb(1'b1, REG_FLAGS, 32'h5);
    wb(1'b1, REG_FDATA, 32'hff);
    run(3'd4);
    chk("skip", skip_o, 1'b1);
    rd(REG_CTRL, 32'h1, "ctrl");
    rd(REG_FDATA, 32'h0, "file");
    rd(REG_FLAGS, 32'h5, "flags");
    run(3'd5);
    chk("work", working_register_o, 8'h01);
    chk("skip", skip_o, 1'b0);
    run(3'd6);
    chk("work", working_register_o, 8'haa);
  endtask : t_skip
  task automatic t_noskip;
    wb(1'b1, REG_FDATA, 32'h7f);
    run(3'd3);
    chk("work", working_register_o, 8'h80);
    rd(REG_FLAGS, 32'((1 << FLAG_SWRAP) | (1 << FLAG_NIB)), "flags");
    wb(1'b1, REG_FDATA, 32'h10);
    run(3'd7);
    chk("work", working_register_o, 8'h11);
    chk("skip", skip_o, 1'b0);
    rd(REG_FDATA, 32'h10, "file");
    rd(REG_FLAGS, 32'((1 << FLAG_SWRAP) | (1 << FLAG_NIB)), "flags");
    run(3'd0);
    chk("work", working_register_o, 8'hff);
  endtask : t_noskip
  task automatic stop_test;
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_literal;
    t_inc;
    t_skip;
    t_noskip;
    stop_test;
  end
  initial begin
    #20000;
    errors++;
    stop_test;
  end
endmodule : tb_increment_and_literal_ops
